// ### logic/adc_sequencer_control.sv
// Purpose: Start, timing, result and flag control of a 10-bit converter
// Assumes: APB slave, analog core presents its code at the last tick
// Notes:   All outputs are registered
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ns

module adc_sequencer_control (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [9:0]  core_result,
  input  wire logic [7:1]  trigger_flags,
  input  wire logic        global_irq_enable,
  input  wire logic        irq_vector_taken,
  input  wire logic [7:0]  port_pins,
  output logic [7:0]       port_read,
  output logic [7:0]       input_buffer_enable,
  output logic             converter_power,
  output logic             core_sample,
  output logic             core_init,
  output logic             core_bipolar,
  output logic [5:0]       core_channel,
  output logic             conv_irq
);
  logic [7:0]  pin_input_disable;
  logic        converter_on_bit;
  logic        start_conversion_bit;
  logic        auto_trigger_enable;
  logic        conversion_done_flag;
  logic        conversion_irq_enable;
  logic [2:0]  clock_divider_select;
  logic        bipolar_select;
  logic        comparator_mux_enable;
  logic [1:0]  reserved_bits;
  logic        left_adjust_select;
  logic [2:0]  trigger_source_select;
  logic [5:0]  input_select_field;
  logic [9:0]  conversion_result;
  logic        result_locked;
  logic        first_pending;
  logic [4:0]  tick_count;
  logic [4:0]  conv_length;
  logic [7:0]  pin_sync1;
  logic [7:0]  pin_sync2;
  adc_ctrl_pkg::seq_state_e state;
  adc_ctrl_pkg::seq_state_e next_state;

  adc_conv_if cv ();

  // APB decode
  logic [3:0]  reg_index;
  logic        addr_ok;
  logic        access;
  logic        wr_en;
  logic        rd_en;
  logic        wr_a;
  logic        wr_b;
  logic        wr_did;
  logic        wr_chan;
  logic        rd_low;
  logic        rd_high;
  logic        trigger_pulse;
  logic        auto_start;
  logic        sw_start;
  logic        start_now;
  logic        last_tick;
  logic        finishing;
  logic        on_next;
  logic [9:0]  shown;
  logic [7:0]  low_byte;
  logic [7:0]  high_byte;
  logic [7:0]  ctrl_a_view;
  logic [7:0]  ctrl_b_view;
  logic [7:0]  read_byte;

  assign reg_index = paddr[5:2];
  assign addr_ok   = (paddr[31:6] == 26'h0) && (paddr[1:0] == 2'h0) &&
                     (reg_index == adc_ctrl_pkg::IDX_DIGITAL_INPUT_DISABLE ||
                      reg_index == adc_ctrl_pkg::IDX_RESULT_LOW ||
                      reg_index == adc_ctrl_pkg::IDX_RESULT_HIGH ||
                      reg_index == adc_ctrl_pkg::IDX_CONTROL_A ||
                      reg_index == adc_ctrl_pkg::IDX_CONTROL_B ||
                      reg_index == adc_ctrl_pkg::IDX_CHANNEL_SELECT ||
                      reg_index == adc_ctrl_pkg::IDX_SIDEBAND);
  // Zero wait states: the access phase completes in its first cycle
  assign access  = psel & penable;
  assign wr_en   = access & pwrite & addr_ok;
  assign rd_en   = access & ~pwrite & addr_ok;
  assign wr_a    = wr_en && reg_index == adc_ctrl_pkg::IDX_CONTROL_A;
  assign wr_b    = wr_en && reg_index == adc_ctrl_pkg::IDX_CONTROL_B;
  assign wr_did  = wr_en &&
                   reg_index == adc_ctrl_pkg::IDX_DIGITAL_INPUT_DISABLE;
  assign wr_chan = wr_en && reg_index == adc_ctrl_pkg::IDX_CHANNEL_SELECT;
  assign rd_low  = rd_en && reg_index == adc_ctrl_pkg::IDX_RESULT_LOW;
  assign rd_high = rd_en && reg_index == adc_ctrl_pkg::IDX_RESULT_HIGH;

  // Enable state as it stands after this cycle, so a start in the
  // enabling write is seen
  assign on_next = wr_a ? pwdata[adc_ctrl_pkg::CA_ON] : converter_on_bit;

  adc_trigger_select u_trigger (
    .pclk          (pclk),
    .presetn       (presetn),
    .source_select (trigger_source_select),
    .trigger_flags (trigger_flags),
    .trigger_pulse (trigger_pulse)
  );

  // Free running restarts off its own completion, not off the flag edge
  assign auto_start = auto_trigger_enable & (
      (trigger_source_select == adc_ctrl_pkg::TRIG_FREE_RUN) ? finishing
                                                             : trigger_pulse
      );
  // Writing zero to the start bit does nothing
  assign sw_start  = wr_a & pwdata[adc_ctrl_pkg::CA_START];
  assign start_now = on_next & (sw_start | auto_start) &
                     (state != adc_ctrl_pkg::ST_CONV || finishing);

  // Divider runs only while converting, so each conversion spans whole
  // converter clock periods from its start
  assign cv.run            = converter_on_bit &
                             (state == adc_ctrl_pkg::ST_CONV);
  assign cv.divider_select = clock_divider_select;

  adc_prescaler u_prescaler (
    .pclk    (pclk),
    .presetn (presetn),
    .cv      (cv)
  );

  assign conv_length = first_pending ? adc_ctrl_pkg::FIRST_CONV_CYCLES
                                     : adc_ctrl_pkg::NORMAL_CONV_CYCLES;
  assign last_tick = cv.tick && (tick_count == 5'(conv_length - 5'd1));
  assign finishing = (state == adc_ctrl_pkg::ST_CONV) && last_tick &&
                     converter_on_bit;

  always_comb begin
    next_state = state;
    case (state)
      adc_ctrl_pkg::ST_OFF:
        next_state = on_next ? (start_now ? adc_ctrl_pkg::ST_CONV
                                          : adc_ctrl_pkg::ST_IDLE)
                             : adc_ctrl_pkg::ST_OFF;
      adc_ctrl_pkg::ST_IDLE:
        next_state = !on_next ? adc_ctrl_pkg::ST_OFF
                   : start_now ? adc_ctrl_pkg::ST_CONV
                   : adc_ctrl_pkg::ST_IDLE;
      adc_ctrl_pkg::ST_CONV:
        next_state = !on_next ? adc_ctrl_pkg::ST_OFF
                   : (finishing && !start_now) ? adc_ctrl_pkg::ST_IDLE
                   : adc_ctrl_pkg::ST_CONV;
      default:
        next_state = adc_ctrl_pkg::ST_OFF;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= adc_ctrl_pkg::ST_OFF;
      tick_count <= 5'd0;
    end else begin
      state <= next_state;
      if (start_now || next_state != adc_ctrl_pkg::ST_CONV) begin
        tick_count <= 5'd0;
      end else if (cv.tick) begin
        tick_count <= 5'(tick_count + 5'd1);
      end
    end
  end

  // Initialisation owed after every enable; consumed by the first finish
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_pending <= 1'b1;
    end else if (!converter_on_bit) begin
      first_pending <= 1'b1;
    end else if (finishing) begin
      first_pending <= 1'b0;
    end
  end

  assign start_conversion_bit = (state == adc_ctrl_pkg::ST_CONV);

  // Control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_on_bit      <= 1'b0;
      auto_trigger_enable   <= 1'b0;
      conversion_irq_enable <= 1'b0;
      clock_divider_select  <= 3'h0;
      bipolar_select        <= 1'b0;
      comparator_mux_enable <= 1'b0;
      reserved_bits         <= 2'h0;
      left_adjust_select    <= 1'b0;
      trigger_source_select <= 3'h0;
      pin_input_disable     <= adc_ctrl_pkg::RESET_BYTE;
    end else begin
      if (wr_a) begin
        converter_on_bit      <= pwdata[adc_ctrl_pkg::CA_ON];
        auto_trigger_enable   <= pwdata[adc_ctrl_pkg::CA_AUTO];
        conversion_irq_enable <= pwdata[adc_ctrl_pkg::CA_IRQ_EN];
        clock_divider_select  <= pwdata[2:0];
      end
      if (wr_b) begin
        bipolar_select        <= pwdata[adc_ctrl_pkg::CB_BIPOLAR];
        comparator_mux_enable <= pwdata[adc_ctrl_pkg::CB_CMP_MUX];
        reserved_bits <= {pwdata[adc_ctrl_pkg::CB_RES5],
                          pwdata[adc_ctrl_pkg::CB_RES3]};
        left_adjust_select    <= pwdata[adc_ctrl_pkg::CB_LEFT];
        trigger_source_select <= pwdata[2:0];
      end
      if (wr_did) begin
        pin_input_disable <= pwdata[7:0];
      end
    end
  end

  // Channel write is held back while converting
  logic [5:0] channel_pending;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_select_field <= 6'h00;
      channel_pending    <= 6'h00;
    end else begin
      if (wr_chan) begin
        channel_pending <= pwdata[5:0];
      end
      if (state != adc_ctrl_pkg::ST_CONV || finishing) begin
        input_select_field <= wr_chan ? pwdata[5:0] : channel_pending;
      end
    end
  end

  // Result capture and the read lock; a capture during the lock is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_result <= 10'h000;
      result_locked     <= 1'b0;
    end else begin
      if (finishing && !result_locked) begin
        conversion_result <= core_result;
      end
      if (rd_high) begin
        result_locked <= 1'b0;
      end else if (rd_low) begin
        result_locked <= 1'b1;
      end
    end
  end

  // Set wins over a software or vector clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_done_flag <= 1'b0;
    end else if (finishing) begin
      conversion_done_flag <= 1'b1;
    end else if (irq_vector_taken ||
                 (wr_a && pwdata[adc_ctrl_pkg::CA_DONE])) begin
      conversion_done_flag <= 1'b0;
    end
  end

  // Presentation follows the select bit combinationally
  assign shown     = conversion_result;
  assign high_byte = left_adjust_select ? shown[9:2]
                                        : {6'h00, shown[9:8]};
  assign low_byte  = left_adjust_select ? {shown[1:0], 6'h00}
                                        : shown[7:0];

  assign ctrl_a_view = {converter_on_bit, start_conversion_bit,
                        auto_trigger_enable, conversion_done_flag,
                        conversion_irq_enable, clock_divider_select};
  assign ctrl_b_view = {bipolar_select, comparator_mux_enable,
                        reserved_bits[1], left_adjust_select,
                        reserved_bits[0], trigger_source_select};

  always_comb begin
    read_byte = 8'h00;
    case (reg_index)
      adc_ctrl_pkg::IDX_DIGITAL_INPUT_DISABLE: read_byte = pin_input_disable;
      adc_ctrl_pkg::IDX_RESULT_LOW:      read_byte = low_byte;
      adc_ctrl_pkg::IDX_RESULT_HIGH:     read_byte = high_byte;
      adc_ctrl_pkg::IDX_CONTROL_A:       read_byte = ctrl_a_view;
      adc_ctrl_pkg::IDX_CONTROL_B:       read_byte = ctrl_b_view;
      adc_ctrl_pkg::IDX_CHANNEL_SELECT:  read_byte = {2'h0, channel_pending};
      adc_ctrl_pkg::IDX_SIDEBAND:        read_byte = port_read;
      default:                           read_byte = 8'h00;
    endcase
  end

  // APB answer registered; pready is loaded in the setup cycle so access
  // completes at its first edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok;
      prdata  <= (psel & ~penable & ~pwrite & addr_ok) ? {24'h0, read_byte}
                                                       : 32'h0000_0000;
    end
  end

  // Pin input path: two-stage synchroniser then masking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync1 <= 8'h00;
      pin_sync2 <= 8'h00;
      port_read <= 8'h00;
    end else begin
      pin_sync1 <= port_pins;
      pin_sync2 <= pin_sync1;
      port_read <= pin_sync2 & ~pin_input_disable;
    end
  end

  // Core and pin-side outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_buffer_enable <= 8'hFF;
      converter_power     <= 1'b0;
      core_sample         <= 1'b0;
      core_init           <= 1'b0;
      core_bipolar        <= 1'b0;
      core_channel        <= 6'h00;
      conv_irq            <= 1'b0;
    end else begin
      input_buffer_enable <= ~pin_input_disable;
      converter_power     <= on_next;
      core_sample         <= start_now;
      core_init           <= (state == adc_ctrl_pkg::ST_CONV) & first_pending;
      core_bipolar        <= bipolar_select;
      core_channel        <= input_select_field;
      conv_irq <= conversion_done_flag & conversion_irq_enable &
                  global_irq_enable & ~irq_vector_taken;
    end
  end
endmodule

// ### logic/adc_ctrl_pkg.sv
// Purpose: Shared constants for the converter sequencer control block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   Printed offsets are not all multiples of four, so they are indices
package adc_ctrl_pkg;
  // Register indices; byte address is four times the index
  localparam logic [3:0] IDX_DIGITAL_INPUT_DISABLE = 4'h1;
  localparam logic [3:0] IDX_RESULT_LOW            = 4'h4;
  localparam logic [3:0] IDX_RESULT_HIGH           = 4'h5;
  localparam logic [3:0] IDX_CONTROL_A             = 4'h6;
  localparam logic [3:0] IDX_CONTROL_B             = 4'h3;
  localparam logic [3:0] IDX_CHANNEL_SELECT        = 4'h7;
  localparam logic [3:0] IDX_SIDEBAND              = 4'h8;

  // Control A bit positions
  localparam int CA_ON      = 7;
  localparam int CA_START   = 6;
  localparam int CA_AUTO    = 5;
  localparam int CA_DONE    = 4;
  localparam int CA_IRQ_EN  = 3;
  // Control B bit positions
  localparam int CB_BIPOLAR = 7;
  localparam int CB_CMP_MUX = 6;
  localparam int CB_RES5    = 5;
  localparam int CB_LEFT    = 4;
  localparam int CB_RES3    = 3;

  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Conversion lengths in converter clocks
  localparam logic [4:0] FIRST_CONV_CYCLES  = 5'd25;
  localparam logic [4:0] NORMAL_CONV_CYCLES = 5'd13;

  localparam logic [2:0] TRIG_FREE_RUN = 3'h0;

  typedef enum logic [1:0] {
    ST_OFF  = 2'b00,
    ST_IDLE = 2'b01,
    ST_CONV = 2'b11
  } seq_state_e;
endpackage

// ### logic/adc_conv_if.sv
// Purpose: Carrier between sequencer and prescaler
// Assumes: Single clock domain
// Notes:   tick is one system clock wide
`timescale 1ns/1ns
interface adc_conv_if;
  logic       run;
  logic [2:0] divider_select;
  logic       tick;
  modport ctrl (output run, output divider_select, input tick);
  modport div  (input run, input divider_select, output tick);
endinterface

// ### logic/adc_prescaler.sv
// Purpose: Converter clock enable from the system clock
// Assumes: Codes 0 and 1 both give division by two
// Notes:   Counter held at zero while no conversion runs
`timescale 1ns/1ns
module adc_prescaler (
  input  wire logic pclk,
  input  wire logic presetn,
  adc_conv_if.div   cv
);
  logic [6:0] count;
  logic [6:0] limit;
  logic [2:0] code;

  assign code  = (cv.divider_select == 3'h0) ? 3'h1 : cv.divider_select;
  assign limit = 7'((8'h01 << code) - 8'h01);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count   <= 7'h00;
      cv.tick <= 1'b0;
    end else if (!cv.run) begin
      count   <= 7'h00;
      cv.tick <= 1'b0;
    end else begin
      cv.tick <= (count >= limit);
      count   <= (count >= limit) ? 7'h00 : 7'(count + 7'h01);
    end
  end
endmodule

// ### logic/adc_trigger_select.sv
// Purpose: Selects the auto trigger source and finds its rising edge
// Assumes: Trigger flags come from the same clock domain
// Notes:   A source change is compared against the previously selected flag
`timescale 1ns/1ns
module adc_trigger_select (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [2:0] source_select,
  input  wire logic [7:1] trigger_flags,
  output logic            trigger_pulse
);
  logic selected;
  logic selected_prev;

  // Code zero has no flag: free running never edges here
  assign selected = (source_select == adc_ctrl_pkg::TRIG_FREE_RUN) ? 1'b0
                    : trigger_flags[source_select];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      selected_prev <= 1'b0;
    end else begin
      selected_prev <= selected;
    end
  end

  // Switching to a set flag from a clear one reads as an edge
  assign trigger_pulse = selected & ~selected_prev;
endmodule

// ### bench/adc_sequencer_control_assertions.sv
// Purpose: Port-level checks of the converter sequencer control block
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Bound to the top module from the bench top file
`timescale 1ns/1ns
module adc_sequencer_control_assertions (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic        core_sample,
  input wire logic        converter_power,
  input wire logic        global_irq_enable,
  input wire logic        conv_irq,
  input wire logic [7:0]  port_read,
  input wire logic [7:0]  input_buffer_enable
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_setup_gets_ready: assert property (psel && !penable |=> pready)
    else $error("setup cycle not answered in the next cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside an access cycle");
  a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero outside the answer");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("error response without ready");
  a_sample_one_cycle: assert property (core_sample |=> !core_sample)
    else $error("sample strobe longer than one cycle");
  a_sample_needs_power: assert property (core_sample |-> converter_power)
    else $error("sample strobe while converter is off");
  a_off_no_sample: assert property
    ($fell(converter_power) |-> !core_sample ##1 !core_sample)
    else $error("sample strobe after the converter was switched off");
  a_irq_needs_global: assert property
    (!global_irq_enable |=> !conv_irq)
    else $error("interrupt raised with global enable low");
  a_pin_masked_zero: assert property
    ($stable(input_buffer_enable) |->
     (port_read & ~input_buffer_enable) == 8'h00)
    else $error("disabled pin reads as one");

  c_irq: cover property (conv_irq);
  c_refused: cover property (pslverr);
  c_power_off: cover property ($fell(converter_power));
endmodule

// ### bench/adc_core_model.sv
// Purpose: Behavioural analog core and trigger flag sources
// Assumes: Code is taken at the sample strobe and held for the conversion
// Notes:   Powered-down core output is shown inverted, never a stale value
`timescale 1ns/1ns
module adc_core_model (
  input  wire logic       pclk,
  input  wire logic       converter_power,
  input  wire logic       core_sample,
  input  wire logic [9:0] code,
  input  wire logic [7:1] fire,
  output logic      [9:0] core_result,
  output logic      [7:1] trigger_flags
);
  logic [9:0] held = 10'h000;

  always_ff @(posedge pclk) begin
    if (core_sample) begin
      held <= code;
    end
  end
  // An unpowered core drives nothing useful; invert to expose misuse
  assign core_result   = converter_power ? held : ~held;
  assign trigger_flags = fire;
endmodule

// ### bench/tb_top.sv
// Purpose: Self-checking bench of the converter sequencer control block
// Assumes: APB master on pclk, core and flags from a behavioural model
// Notes:   Duration checks allow for the polling granularity
`timescale 1ns/1ns
module tb_top;
  localparam logic [3:0] CA = adc_ctrl_pkg::IDX_CONTROL_A;
  localparam logic [3:0] CB = adc_ctrl_pkg::IDX_CONTROL_B;
  localparam logic [3:0] LO = adc_ctrl_pkg::IDX_RESULT_LOW;
  localparam logic [3:0] HI = adc_ctrl_pkg::IDX_RESULT_HIGH;
  localparam logic [3:0] DI = adc_ctrl_pkg::IDX_DIGITAL_INPUT_DISABLE;
  typedef struct packed {logic [3:0] i; logic [7:0] d, e; logic err;} row_s;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, pready, pslverr, core_sample, core_init;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  logic [9:0]  core_result, code = 10'h2C9;
  logic [7:1]  trigger_flags, fire = 7'h00;
  logic        global_irq_enable = 1'b0, irq_vector_taken = 1'b0, er;
  logic [7:0]  port_pins = 8'h00, port_read, input_buffer_enable;
  logic        converter_power, core_bipolar, conv_irq;
  logic [5:0]  core_channel;
  logic [3:0]  ri [5] = '{DI, CB, LO, HI, CA};
  row_s        rows [6] = '{'{DI, 8'h5A, 8'h5A, 1'b0},
    '{CB, 8'h28, 8'h28, 1'b0}, '{CB, 8'h00, 8'h00, 1'b0},
    '{CA, 8'h05, 8'h05, 1'b0}, '{CA, 8'h00, 8'h00, 1'b0},
    '{4'hF, 8'h77, 8'h00, 1'b1}};
  int          failures = 0, checks = 0, samples = 0, n0, d;
  time         t0;

  always #10 pclk = ~pclk;
  always @(negedge pclk) if (core_sample === 1'b1) samples++;

  adc_sequencer_control adc_sequencer_control_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .core_result(core_result),
    .trigger_flags(trigger_flags), .global_irq_enable(global_irq_enable),
    .irq_vector_taken(irq_vector_taken), .port_pins(port_pins),
    .port_read(port_read), .input_buffer_enable(input_buffer_enable),
    .converter_power(converter_power), .core_sample(core_sample),
    .core_init(core_init), .core_bipolar(core_bipolar),
    .core_channel(core_channel), .conv_irq(conv_irq));
  adc_core_model adc_core_model_i (.pclk(pclk),
    .converter_power(converter_power), .core_sample(core_sample),
    .code(code), .fire(fire), .core_result(core_result),
    .trigger_flags(trigger_flags));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Ready, read data and error are all taken at the completing rising edge
  task automatic apb(input logic w, input logic [3:0] i, input logic [7:0] v);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w;
    paddr <= {26'h0, i, 2'b00}; pwdata <= {24'h0, v};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      failures++;
      close_out();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] i, input logic [7:0] v);
    apb(1'b1, i, v);
  endtask
  task automatic rdc(input logic [3:0] i, input logic [7:0] e);
    apb(1'b0, i, 8'h00);
    chk(rd, {24'h0, e});
  endtask
  task automatic start(input logic [7:0] v);
    wr(CA, v);
    t0 = $time;
  endtask
  task automatic finish(input int n, input int dv);
    int k;
    k = 0;
    apb(1'b0, CA, 8'h00);
    while (rd[6] !== 1'b0 && k < 2000) begin
      apb(1'b0, CA, 8'h00);
      k++;
    end
    if (rd[6] !== 1'b0) begin
      failures++;
      close_out();
    end
    k = int'(($time - t0) / 20);
    if (n > 0) chk(k >= n * dv - 4 && k <= n * dv + 8, 1'b1);
  endtask
  task automatic close_out;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #400000;
    failures++;
    $display("watchdog expired");
    close_out();
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk(input_buffer_enable, 8'hFF);
    foreach (ri[j]) rdc(ri[j], 8'h00);
    $display("test reset done");
    foreach (rows[j]) begin
      wr(rows[j].i, rows[j].d);
      chk(er, rows[j].err);
      rdc(rows[j].i, rows[j].e);
      chk(er, rows[j].err);
    end
    $display("test register table done");
    start(8'hC0);
    rdc(CA, 8'hC0);
    chk(core_init, 1'b1);
    wr(CA, 8'h80);
    rdc(CA, 8'hC0);
    finish(25, 2);
    rdc(CA, 8'h90);
    rdc(LO, 8'hC9);
    rdc(HI, 8'h02);
    wr(CB, 8'h10);
    rdc(LO, 8'h40);
    rdc(HI, 8'hB2);
    wr(CB, 8'h00);
    wr(CA, 8'h90);
    rdc(CA, 8'h80);
    $display("test first conversion done");
    for (int k = 0; k < 8; k++) begin
      d = (k < 2) ? 2 : (1 << k);
      start(8'hC0 | 8'(k));
      finish(13, d);
    end
    $display("test divider done");
    rdc(LO, 8'hC9);
    code = 10'h13A;
    start(8'hC0);
    finish(13, 2);
    rdc(HI, 8'h02);
    start(8'hC0);
    finish(13, 2);
    rdc(LO, 8'h3A);
    rdc(HI, 8'h01);
    $display("test result lock done");
    wr(adc_ctrl_pkg::IDX_CHANNEL_SELECT, 8'h00);
    start(8'hC7);
    wr(adc_ctrl_pkg::IDX_CHANNEL_SELECT, 8'h05);
    chk(core_channel, 6'h00);
    chk(core_init, 1'b0);
    finish(13, 128);
    chk(core_channel, 6'h05);
    wr(CB, 8'h80);
    repeat (2) @(negedge pclk);
    chk(core_bipolar, 1'b1);
    wr(CB, 8'h00);
    start(8'hC7);
    wr(CA, 8'h17);
    rdc(CA, 8'h07);
    chk(converter_power, 1'b0);
    repeat (1800) @(posedge pclk);
    rdc(CA, 8'h07);
    $display("test channel and abort done");
    global_irq_enable <= 1'b1;
    start(8'hC8);
    finish(25, 2);
    chk(conv_irq, 1'b1);
    @(posedge pclk) global_irq_enable <= 1'b0;
    repeat (2) @(negedge pclk);
    chk(conv_irq, 1'b0);
    @(posedge pclk) global_irq_enable <= 1'b1;
    repeat (2) @(negedge pclk);
    chk(conv_irq, 1'b1);
    @(posedge pclk) irq_vector_taken <= 1'b1;
    @(posedge pclk) irq_vector_taken <= 1'b0;
    repeat (2) @(negedge pclk);
    chk(conv_irq, 1'b0);
    rdc(CA, 8'h88);
    $display("test interrupt done");
    wr(CA, 8'hA0);
    for (int k = 1; k < 8; k++) begin
      wr(CB, 8'(k));
      n0 = samples;
      @(posedge pclk) fire[k] <= 1'b1;
      repeat (4) @(posedge pclk);
      chk(samples - n0, 1);
      finish(0, 2);
      @(posedge pclk) fire[k] <= 1'b0;
    end
    wr(CA, 8'h80);
    wr(CB, 8'h03);
    n0 = samples;
    @(posedge pclk) fire[3] <= 1'b1;
    repeat (6) @(posedge pclk);
    chk(samples - n0, 0);
    wr(CB, 8'h02);
    wr(CA, 8'hA0);
    wr(CB, 8'h03);
    repeat (4) @(posedge pclk);
    chk(samples - n0, 1);
    finish(0, 2);
    @(posedge pclk) fire[3] <= 1'b0;
    n0 = samples;
    wr(CB, 8'h00);
    repeat (6) @(posedge pclk);
    chk(samples - n0, 0);
    wr(CA, 8'hE0);
    repeat (200) @(posedge pclk);
    chk((samples - n0) > 5, 1'b1);
    wr(CA, 8'h80);
    repeat (60) @(posedge pclk);
    n0 = samples;
    repeat (100) @(posedge pclk);
    chk(samples - n0, 0);
    $display("test triggers done");
    wr(DI, 8'h0F);
    @(posedge pclk) port_pins <= 8'hFF;
    repeat (6) @(negedge pclk);
    chk(port_read, 8'hF0);
    chk(input_buffer_enable, 8'hF0);
    rdc(adc_ctrl_pkg::IDX_SIDEBAND, 8'hF0);
    $display("test pin disable done");
    close_out();
  end
endmodule

bind adc_sequencer_control adc_sequencer_control_assertions chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .core_sample(core_sample), .converter_power(converter_power),
  .global_irq_enable(global_irq_enable), .conv_irq(conv_irq),
  .port_read(port_read), .input_buffer_enable(input_buffer_enable));
